// File: hw/uch_packet_handler.sv
// Purpose: Receive framed command packets, dispatch them, send replies and error frames
// Assumes: Command actions sit outside on the cmd/pld/rsp ports
// Notes:   Payload streams out unchecked; discard it on pkt_bad
`timescale 1ns/1ps
module uch_packet_handler
    import uch_pkg::*;
#(
    parameter int         GAP_CYCLES = GAP_DEFAULT,  // Inter-byte timeout in clocks
    parameter logic [9:0] BIT_DIV    = BAUD_DIV,     // Clocks per bit minus one
    parameter logic [9:0] HALF_BIT   = HALF_DIV      // Clocks to mid start bit minus one
) (
    input  wire logic        ref_clk,         // System clock
    input  wire logic        rst_n,           // Synchronous reset
    input  wire logic        serial_in,       // Link receive line
    output logic             serial_out,      // Link transmit line
    output logic             cmd_start,       // Command accepted, pulse
    output uch_hdr_type      cmd_hdr,         // Accepted command header
    output logic             pld_valid,       // Payload data byte strobe
    output logic [7:0]       pld_data,        // Payload data byte
    output logic             pkt_ok,          // Packet passed checks, pulse
    output logic             pkt_bad,         // Packet rejected, pulse
    input  wire logic        cmd_done,        // Command finished, pulse
    input  wire uch_rsp_type cmd_rsp,         // Outcome with cmd_done
    input  wire logic        rsp_valid,       // Reply data byte valid
    input  wire logic [7:0]  rsp_data,        // Reply data byte
    output logic             rsp_ready        // Reply byte taken
);
    // ------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------
    logic       rx_busy;
    logic [9:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic       rx_stb;
    logic [7:0] rx_byte;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_busy <= 1'b0;
            rx_cnt  <= 10'h0;
            rx_bit  <= 4'h0;
            rx_sh   <= 8'h0;
            rx_stb  <= 1'b0;
            rx_byte <= 8'h0;
        end else begin
            rx_stb <= 1'b0;
            if (!rx_busy) begin
                rx_busy <= !serial_in;
                rx_cnt  <= HALF_BIT;
                rx_bit  <= 4'h0;
            end else if (rx_cnt != 10'h0) begin
                rx_cnt <= rx_cnt - 10'h1;
            end else begin
                rx_cnt <= BIT_DIV;
                if (rx_bit == 4'h9) begin
                    rx_busy <= 1'b0;
                    rx_stb  <= serial_in;                  // Framing error drops the byte
                    rx_byte <= rx_sh;
                end else begin
                    rx_sh  <= {serial_in, rx_sh[7:1]};
                    rx_bit <= rx_bit + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Frame parser
    // ------------------------------------------------------------
    uch_parse_type pst;
    logic [15:0]   pcnt;
    logic [31:0]   csum;
    logic [31:0]   sum;
    logic [31:0]   gap_cnt;
    logic [7:0]    exp_seq;
    logic          exec_busy;
    logic          need_l;
    uch_hdr_type   hdr;

    wire        st_hit    = rx_byte == START_MARK[{pcnt[1:0], 3'b000} +: 8];
    wire        end_hit   = rx_byte == END_MARK[{pcnt[1:0], 3'b000} +: 8];
    wire        frame_open = (pst != P_START) || (pcnt != 16'h0);
    wire        gap_hit   = frame_open && !rx_stb && gap_cnt == 32'(GAP_CYCLES - 1);
    wire        cont      = hdr.seq != 8'h0;
    wire        seq_ok    = !cont || hdr.seq == exp_seq;
    wire        len_ok    = cont || hdr.len >= CMD_BYTES;
    wire [15:0] rx_len    = {rx_byte, hdr.len[7:0]};
    wire        trail_stb = rx_stb && pst == P_TRAIL;
    wire        trail_end = trail_stb && pcnt == 16'h3;
    wire        good      = end_hit && sum == csum && seq_ok && len_ok && !exec_busy;
    wire        ok_evt    = trail_end && good;
    wire        bad_evt   = trail_stb && (!end_hit || (pcnt == 16'h3 && !good));
    wire        last_pkt  = hdr.len != FULL_PKT_LEN;
    wire        pay_data  = rx_stb && pst == P_PAY && (cont || pcnt >= CMD_BYTES);
    wire [31:0] rx_add    = sum + {24'h0, rx_byte};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gap_cnt <= 32'h0;
        end else begin
            gap_cnt <= (rx_stb || !frame_open) ? 32'h0 : gap_cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || gap_hit || bad_evt) begin
            pst  <= P_START;
            pcnt <= 16'h0;
        end else if (rx_stb) begin
            pcnt <= pcnt + 16'h1;
            case (pst)
                P_START: begin
                    if (!st_hit) begin
                        pcnt <= {15'h0, rx_byte == START_MARK[7:0]};
                    end else if (pcnt == 16'h3) begin
                        pst  <= P_HDR;
                        pcnt <= 16'h0;
                        sum  <= 32'h0;
                    end
                end
                P_HDR: begin
                    if (pcnt < 16'h4) begin
                        csum[{pcnt[1:0], 3'b000} +: 8] <= rx_byte;
                    end else begin
                        sum <= rx_add;
                    end
                    if (pcnt == 16'h4) hdr.flags <= rx_byte;
                    if (pcnt == 16'h5) hdr.seq <= rx_byte;
                    if (pcnt == 16'h6) hdr.len[7:0] <= rx_byte;
                    if (pcnt == 16'h7) begin
                        hdr.len[15:8] <= rx_byte;
                        pst  <= (rx_len == 16'h0) ? P_TRAIL : P_PAY;
                        pcnt <= 16'h0;
                    end
                end
                P_PAY: begin
                    sum <= rx_add;
                    if (!cont && pcnt == 16'h0) hdr.cmd <= rx_byte;
                    if (!cont && pcnt == 16'h1) hdr.grp <= rx_byte;
                    if (pcnt == hdr.len - 16'h1) begin
                        pst  <= P_TRAIL;
                        pcnt <= 16'h0;
                    end
                end
                default: begin
                    if (pcnt == 16'h3) begin
                        pst  <= P_START;
                        pcnt <= 16'h0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Dispatch
    // ------------------------------------------------------------
    wire is_file  = hdr.grp == GRP_FILE && hdr.cmd >= FILE_FIRST && hdr.cmd <= FILE_LAST;
    wire is_test  = hdr.grp == GRP_TEST && hdr.cmd >= TEST_FIRST && hdr.cmd <= TEST_LAST
                    && hdr.cmd != TEST_HOLE;
    wire bad_size = (hdr.grp == GRP_FILE && hdr.cmd == FILE_WRITE_SIZE_CMD
                     && hdr.len != CMD_BYTES + FILE_WRITE_SIZE_IN)
                 || (hdr.grp == GRP_TEST && hdr.cmd == CONTROLLER_POWER_UP_CMD
                     && hdr.len != CMD_BYTES + CONTROLLER_POWER_UP_IN);
    wire known    = (is_file || is_test) && !bad_size;
    wire need_now = hdr.flags[FLG_READ] || hdr.flags[FLG_REPLY];
    wire cmd_need = cont ? need_l : need_now;
    wire dispatch = ok_evt && last_pkt;
    wire fast_nak = dispatch && !known && cmd_need;
    wire rep_set  = fast_nak || (cmd_done && exec_busy && need_l);
    wire err_set  = gap_hit || bad_evt;

    uch_rsp_type rep_rsp;
    logic        err_pend;
    logic        rep_pend;
    uch_tx_type  tst;
    wire         err_take = tst == T_IDLE && err_pend;
    wire         rep_take = tst == T_IDLE && !err_pend && rep_pend;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            exp_seq   <= 8'h0;
            exec_busy <= 1'b0;
            need_l    <= 1'b0;
            cmd_start <= 1'b0;
            cmd_hdr   <= '0;
            pld_valid <= 1'b0;
            pld_data  <= 8'h0;
            pkt_ok    <= 1'b0;
            pkt_bad   <= 1'b0;
            rep_rsp   <= '0;
            err_pend  <= 1'b0;
            rep_pend  <= 1'b0;
        end else begin
            pld_valid <= pay_data;
            pld_data  <= rx_byte;
            pkt_ok    <= ok_evt;
            pkt_bad   <= bad_evt || gap_hit;
            cmd_start <= dispatch && known;
            err_pend  <= err_set || (err_pend && !err_take);   // Set wins over take
            rep_pend  <= rep_set || (rep_pend && !rep_take);
            if (gap_hit || bad_evt) exp_seq <= 8'h0;
            if (ok_evt) begin
                exp_seq <= last_pkt ? 8'h0 : hdr.seq + 8'h1;
                need_l  <= cmd_need;
                cmd_hdr <= cont ? cmd_hdr : hdr;
            end
            if (dispatch && known) exec_busy <= 1'b1;
            else if (cmd_done) exec_busy <= 1'b0;
            if (fast_nak) rep_rsp <= '{nack: 1'b1, len: 16'h0, sum: 32'h0};
            else if (cmd_done && exec_busy) rep_rsp <= cmd_rsp;
        end
    end

    // ------------------------------------------------------------
    // Frame transmitter
    // ------------------------------------------------------------
    logic [3:0]  tidx;
    logic        terr;
    logic [15:0] tdl;
    logic [31:0] tcs;
    logic [7:0]  tflags;
    logic [7:0]  tseq;
    logic [15:0] tlen;
    logic [9:0]  tx_sh;
    logic [9:0]  tx_cnt;
    logic [3:0]  tx_left;
    logic [7:0]  tbyte;

    wire        tx_busy   = tx_left != 4'h0;
    wire        tx_go     = !tx_busy && tst != T_IDLE && (tst != T_DATA || rsp_valid);
    wire [1:0]  rep_resp  = rep_rsp.nack ? RESP_NACK : RESP_OK;
    wire [7:0]  rep_flags = {cmd_hdr.flags[FLG_READ], 1'b0, rep_resp, 4'h0};
    wire [15:0] rep_len   = rep_rsp.len + CMD_BYTES;
    wire [31:0] rep_cs    = rep_rsp.sum + {24'h0, rep_flags} + {24'h0, cmd_hdr.seq}
                          + {24'h0, rep_len[7:0]} + {24'h0, rep_len[15:8]}
                          + {24'h0, cmd_hdr.cmd} + {24'h0, cmd_hdr.grp};
    wire [3:0]  head_last = terr ? ERR_HEAD_LAST : HEAD_LAST;
    assign rsp_ready = tst == T_DATA && !tx_busy;

    always_comb begin
        tbyte = END_MARK[{tidx[1:0], 3'b000} +: 8];
        if (tst == T_DATA) tbyte = rsp_data;
        else if (tst == T_HEAD) begin
            if (tidx < 4'h4) tbyte = START_MARK[{tidx[1:0], 3'b000} +: 8];
            else if (tidx < 4'h8) tbyte = tcs[{tidx[1:0], 3'b000} +: 8];
            else if (tidx == 4'h8) tbyte = tflags;
            else if (tidx == 4'h9) tbyte = tseq;
            else if (tidx == 4'ha) tbyte = tlen[7:0];
            else if (tidx == 4'hb) tbyte = tlen[15:8];
            else if (tidx == 4'hc) tbyte = cmd_hdr.cmd;
            else tbyte = cmd_hdr.grp;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tst <= T_IDLE;
            tidx <= 4'h0;
            terr <= 1'b0;
            tdl <= 16'h0;
            tcs <= 32'h0;
            tflags <= 8'h0;
            tseq <= 8'h0;
            tlen <= 16'h0;
        end else if (err_take) begin
            tst <= T_HEAD;
            {tidx, terr, tdl} <= {4'h0, 1'b1, 16'h0};
            {tcs, tflags, tseq, tlen} <= {24'h0, ERR_FLAGS, ERR_FLAGS, 8'h0, 16'h0};
        end else if (rep_take) begin
            tst <= T_HEAD;
            {tidx, terr, tdl} <= {4'h0, 1'b0, rep_rsp.len};
            {tcs, tflags, tseq, tlen} <= {rep_cs, rep_flags, cmd_hdr.seq, rep_len};
        end else if (tx_go) begin
            tidx <= tidx + 4'h1;
            case (tst)
                T_HEAD: begin
                    if (tidx == head_last) begin
                        tst  <= (tdl != 16'h0) ? T_DATA : T_TRAIL;
                        tidx <= 4'h0;
                    end
                end
                T_DATA: begin
                    tdl <= tdl - 16'h1;
                    if (tdl == 16'h1) tst <= T_TRAIL;
                    tidx <= 4'h0;
                end
                default: begin
                    if (tidx == 4'h3) tst <= T_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_sh   <= 10'h3ff;
            tx_cnt  <= 10'h0;
            tx_left <= 4'h0;
        end else if (tx_go) begin
            tx_sh   <= {1'b1, tbyte, 1'b0};
            tx_cnt  <= BIT_DIV;
            tx_left <= 4'ha;
        end else if (tx_busy) begin
            tx_cnt <= (tx_cnt == 10'h0) ? BIT_DIV : tx_cnt - 10'h1;
            if (tx_cnt == 10'h0) begin
                tx_sh   <= {1'b1, tx_sh[9:1]};
                tx_left <= tx_left - 4'h1;
            end
        end
    end
    assign serial_out = tx_sh[0];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_start_marks: assert property (tx_go && tst == T_HEAD && tidx < 4'h4
        |-> tbyte == START_MARK[{tidx[1:0], 3'b000} +: 8]) else $error("bad start marker");
    a_trail_marks: assert property (tx_go && tst == T_TRAIL
        |-> tbyte == END_MARK[{tidx[1:0], 3'b000} +: 8]) else $error("bad trailer marker");
    a_err_flags: assert property (tx_go && terr && tst == T_HEAD && tidx == 4'h8
        |-> tbyte == 8'h10) else $error("error frame flags wrong");
    a_err_no_cmd: assert property (tx_go && terr && tst == T_HEAD && tidx == 4'hb
        |=> tst == T_TRAIL) else $error("error frame carries payload");
    a_csum_low: assert property (tx_go && tst == T_HEAD && tidx == 4'h4
        |-> tbyte == tcs[7:0]) else $error("checksum not low byte first");
    a_gap_clear: assert property (gap_hit |=> pst == P_START && pcnt == 16'h0
        ##0 err_pend) else $error("gap did not clear receiver");
    a_bad_error: assert property (bad_evt |=> err_pend ##1 pkt_bad == 1'b0)
        else $error("bad frame gave no error frame");
    a_write_quiet: assert property (cmd_done && exec_busy && !need_l && !fast_nak
        && !rep_pend |=> !rep_pend) else $error("unrequested reply");
    a_nack_unknown: assert property (fast_nak |=> rep_pend && rep_rsp.nack)
        else $error("unknown command not refused");
    a_read_reply: assert property (cmd_done && exec_busy && need_l
        |=> rep_pend) else $error("read gave no reply");
    a_seq_order: assert property (trail_end && cont && hdr.seq != exp_seq
        |-> !ok_evt) else $error("out of order packet accepted");

    c_error_frame: cover property (err_take);
    c_reply_frame: cover property (rep_take ##[1:1000] tst == T_DATA);
    c_dispatch:    cover property (cmd_start);
    c_multi_pkt:   cover property (ok_evt && cont);
endmodule : uch_packet_handler

// File: hw/uch_pkg.sv
// Purpose: Shared constants and carriers for the serial command packet handler
// Assumes: 100 MHz ref_clk, 115200 baud 8N1 link
// Notes:   Marker words hold byte 0 in bits 7:0
package uch_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_HZ      = 100_000_000;
    localparam int         BAUD        = 115200;
    localparam logic [9:0] BAUD_DIV    = 10'(CLK_HZ / BAUD - 1);
    localparam logic [9:0] HALF_DIV    = 10'(CLK_HZ / BAUD / 2 - 1);
    localparam int         GAP_US      = 1000;
    localparam int         GAP_DEFAULT = CLK_HZ / 1_000_000 * GAP_US;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam logic [31:0] START_MARK   = 32'h44434241;
    localparam logic [31:0] END_MARK     = 32'h41424344;
    localparam int          FLG_READ     = 7;
    localparam int          FLG_REPLY    = 6;
    localparam logic [1:0]  RESP_OK      = 2'h0;
    localparam logic [1:0]  RESP_NACK    = 2'h1;
    localparam logic [7:0]  ERR_FLAGS    = 8'h10;
    localparam logic [15:0] CMD_BYTES    = 16'h0002;
    localparam logic [15:0] FULL_PKT_LEN = 16'h0040;
    localparam logic [3:0]  HEAD_LAST    = 4'hd;
    localparam logic [3:0]  ERR_HEAD_LAST = 4'hb;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0]  GRP_FILE                = 8'h00;
    localparam logic [7:0]  GRP_TEST                = 8'h01;
    localparam logic [7:0]  FILE_FIRST              = 8'h2a;
    localparam logic [7:0]  FILE_LAST               = 8'h2e;
    localparam logic [7:0]  FILE_WRITE_SIZE_CMD     = 8'h2a;
    localparam logic [15:0] FILE_WRITE_SIZE_IN      = 16'h0006;
    localparam logic [7:0]  FILE_READ_DATA_CMD      = 8'h2e;
    localparam logic [7:0]  TEST_FIRST              = 8'h01;
    localparam logic [7:0]  TEST_LAST               = 8'h0d;
    localparam logic [7:0]  TEST_HOLE               = 8'h0a;
    localparam logic [7:0]  CONTROLLER_POWER_UP_CMD = 8'h05;
    localparam logic [15:0] CONTROLLER_POWER_UP_IN  = 16'h0002;

    typedef enum logic [1:0] {P_START, P_HDR, P_PAY, P_TRAIL} uch_parse_type;
    typedef enum logic [1:0] {T_IDLE, T_HEAD, T_DATA, T_TRAIL} uch_tx_type;

    typedef struct packed {
        logic [7:0]  flags;
        logic [7:0]  seq;
        logic [15:0] len;
        logic [7:0]  grp;
        logic [7:0]  cmd;
    } uch_hdr_type;

    typedef struct packed {
        logic        nack;
        logic [15:0] len;
        logic [31:0] sum;
    } uch_rsp_type;
endpackage : uch_pkg

// File: testbench/uch_host_model.sv
// Purpose: Host side of the serial command link, sends and collects bytes
// Assumes: 8N1 at BIT_CYC clocks a bit, line idle high
// Notes:   Received bytes queue up in rx_q for the bench to pop
`timescale 1ns/1ps
module uch_host_model
    import uch_pkg::*;
#(
    parameter int BIT_CYC = int'(BAUD_DIV) + 1   // Clocks per bit
) (
    input  wire logic ref_clk,     // System clock
    output logic      serial_in,   // Line into the handler
    input  wire logic serial_out   // Line out of the handler
);
    logic [7:0] rx_q[$];
    logic [7:0] rx_sh;

    initial serial_in = 1'b1;

    // ------------------------------------------------------------
    // Transmit one byte, LSB first, one stop bit
    // ------------------------------------------------------------
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_in <= fr[i];
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask : send_byte

    // ------------------------------------------------------------
    // Receive: sample mid-bit, keep only bytes with a stop bit
    // ------------------------------------------------------------
    initial begin
        forever begin
            @(negedge serial_out);
            repeat (BIT_CYC / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge ref_clk);
                rx_sh[i] = serial_out;
            end
            repeat (BIT_CYC) @(posedge ref_clk);
            if (serial_out === 1'b1) rx_q.push_back(rx_sh);
        end
    end
endmodule : uch_host_model

// File: testbench/uch_packet_handler_tb_top.sv
// Purpose: Self-checking bench for the serial command packet handler
// Assumes: Shortened bit time and byte gap timeout to keep the run short
// Notes:   Every byte costs ten bit times, 160 clocks here
`timescale 1ns/1ps
module uch_packet_handler_tb_top;
    import uch_pkg::*;
    localparam int GAP = 1000;
    localparam int BIT = 16;
    localparam logic [127:0] ERR_FRM = 128'h41424344_10000000_10000000_44434241;
    logic        ref_clk, rst_n, serial_in, serial_out, cmd_start, pld_valid;
    logic        pkt_ok, pkt_bad, cmd_done, rsp_valid, rsp_ready;
    logic [7:0]  pld_data, rsp_data;
    uch_hdr_type cmd_hdr;
    uch_rsp_type cmd_rsp;
    int          failures, total_checks, n_start, n_ok, n_bad;
    logic [7:0]  pld_q[$];

    uch_packet_handler #(.GAP_CYCLES(GAP), .BIT_DIV(10'(BIT - 1)),
                         .HALF_BIT(10'(BIT / 2 - 1))) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .serial_in(serial_in), .serial_out(serial_out),
        .cmd_start(cmd_start), .cmd_hdr(cmd_hdr), .pld_valid(pld_valid),
        .pld_data(pld_data), .pkt_ok(pkt_ok), .pkt_bad(pkt_bad), .cmd_done(cmd_done),
        .cmd_rsp(cmd_rsp), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_ready(rsp_ready));
    uch_host_model #(.BIT_CYC(BIT)) u_host (.ref_clk(ref_clk), .serial_in(serial_in),
                                            .serial_out(serial_out));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Event monitor and reply byte source
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (cmd_start === 1'b1) n_start++;
        if (pkt_ok === 1'b1) n_ok++;
        if (pkt_bad === 1'b1) n_bad++;
        if (pld_valid === 1'b1) pld_q.push_back(pld_data);
        if (rsp_valid && rsp_ready === 1'b1) rsp_valid <= 1'b0;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    // Checksum error adds cs_err so the frame is rejected
    task automatic send_frame(input logic [7:0] fl, input logic [7:0] cmd, input logic [7:0] grp,
                              input logic [15:0] pay, input int n, input logic [7:0] cs_err,
                              input logic [7:0] sq);
        logic [31:0] cs;
        logic [15:0] len;
        len = 16'(n + 2);
        cs = 32'(fl) + sq + len[7:0] + len[15:8] + cmd + grp + cs_err;
        for (int i = 0; i < n; i++) cs += pay[8*(n-1-i)+:8];
        for (int i = 0; i < 4; i++) u_host.send_byte(START_MARK[8*i+:8]);
        for (int i = 0; i < 4; i++) u_host.send_byte(cs[8*i+:8]);
        u_host.send_byte(fl);
        u_host.send_byte(sq);
        u_host.send_byte(len[7:0]);
        u_host.send_byte(len[15:8]);
        u_host.send_byte(cmd);
        u_host.send_byte(grp);
        for (int i = 0; i < n; i++) u_host.send_byte(pay[8*(n-1-i)+:8]);
        for (int i = 0; i < 4; i++) u_host.send_byte(END_MARK[8*i+:8]);
        repeat (4) @(posedge ref_clk);
    endtask : send_frame

    task automatic expect_frame(input logic [159:0] v, input int n);
        for (int k = 0; k < 20000 && u_host.rx_q.size() < n; k++) @(posedge ref_clk);
        for (int i = 0; i < n; i++) check(u_host.rx_q.pop_front(), v[8*(n-1-i)+:8]);
    endtask : expect_frame

    task automatic finish_cmd(input uch_rsp_type r);
        cmd_rsp <= r;
        cmd_done <= 1'b1;
        @(posedge ref_clk);
        cmd_done <= 1'b0;
    endtask : finish_cmd

    initial begin
        repeat (90_000) @(posedge ref_clk);
        failures++;
        stop_test();
    end

    initial begin
        {rst_n, cmd_done, rsp_valid, rsp_data, cmd_rsp} = '0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        check(serial_out, 1'b1);
        // Write with reply requested
        send_frame(8'h40, CONTROLLER_POWER_UP_CMD, GRP_TEST, 16'haa55, 2, 8'h00, 8'h00);
        check({n_ok, n_start}, {32'd1, 32'd1});
        check(cmd_hdr, {8'h40, 8'h00, 16'h0004, 8'h01, 8'h05});
        check({pld_q[0], pld_q[1]}, 16'haa55);
        finish_cmd('0);
        expect_frame(144'h41424344_08000000_00000200_0501_44434241, 18);
        // Read returning one byte
        send_frame(8'hc0, 8'h01, GRP_TEST, 16'h0000, 0, 8'h00, 8'h00);
        check(n_start, 2);
        rsp_data <= 8'h5a;
        rsp_valid <= 1'b1;
        finish_cmd({1'b0, 16'h0001, 32'h0000005a});
        expect_frame(152'h41424344_df000000_80000300_0101_5a_44434241, 19);
        // Bad checksum
        send_frame(8'h40, CONTROLLER_POWER_UP_CMD, GRP_TEST, 16'haa55, 2, 8'h01, 8'h00);
        check({n_bad, n_start}, {32'd1, 32'd2});
        expect_frame(ERR_FRM, 16);
        // Byte gap inside a frame
        for (int i = 0; i < 4; i++) u_host.send_byte(START_MARK[8*i+:8]);
        repeat (GAP + 200) @(posedge ref_clk);
        check(n_bad, 2);
        expect_frame(ERR_FRM, 16);
        // Recovery, then write without reply stays silent
        send_frame(8'h00, CONTROLLER_POWER_UP_CMD, GRP_TEST, 16'h1234, 2, 8'h00, 8'h00);
        check({n_ok, n_start}, {32'd3, 32'd3});
        finish_cmd('0);
        repeat (2000) @(posedge ref_clk);
        check(u_host.rx_q.size(), 0);
        // File write size with wrong length, reply wanted
        send_frame(8'h40, FILE_WRITE_SIZE_CMD, GRP_FILE, 16'h0102, 2, 8'h00, 8'h00);
        check({n_ok, n_start}, {32'd4, 32'd3});
        expect_frame(144'h41424344_3c000000_10000200_2a00_44434241, 18);
        // Continuation packet out of order
        send_frame(8'h40, CONTROLLER_POWER_UP_CMD, GRP_TEST, 16'haa55, 2, 8'h00, 8'h03);
        check({n_bad, n_ok}, {32'd3, 32'd4});
        expect_frame(ERR_FRM, 16);
        stop_test();
    end
endmodule : uch_packet_handler_tb_top
